// *** npecs_host.sv ***
// Host controller that drives program, erase and cache flows of a NAND die.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Cache reads are refused until a page read or copy-back read has been done.
// - Before a cache read, status is polled until cache-ready reads one.
// - A sequential cache read is refused on the last page of the device.
// - Program load is 80h, four address cycles, then data cycles.
// - Completion shows on ready/busy or bit 6; bit 0 then gives pass/fail.
// - Copy-back: 00h, address, 35h, then 85h with destination, then 10h.
// - All pages of one cache program sequence stay in one block.
// - After ending with 15h, bit 5 is polled before a page read, copy-back read, erase or cache read.
// - Erase is 60h, block address cycles, then D0h starts erase.
// - Third and fourth address cycles carry page low, block high.
module npecs_host
	import npecs_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic [7:0]             sAwaddr,
	input  wire logic                   sAwvalid,
	output logic                        sAwready,
	input  wire logic [31:0]            sWdata,
	input  wire logic [3:0]             sWstrb,
	input  wire logic                   sWvalid,
	output logic                        sWready,
	output logic [1:0]                  sBresp,
	output logic                        sBvalid,
	input  wire logic                   sBready,
	input  wire logic [7:0]             sAraddr,
	input  wire logic                   sArvalid,
	output logic                        sArready,
	output logic [31:0]                 sRdata,
	output logic [1:0]                  sRresp,
	output logic                        sRvalid,
	input  wire logic                   sRready,
	output npecs_pkg::npecs_pins_s      nandPins,
	input  wire logic [7:0]             dqIn,
	output logic [7:0]                  dqOut,
	output logic                        dqOe,
	input  wire logic                   readyBusyOutN
);
	import npecs_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_POLL_CMD, S_POLL_RD, S_CMD1, S_ADDR, S_CMD2, S_WB,
		S_WAITRB, S_ST_CMD, S_ST_RD, S_DIN, S_DOUT
	} npecs_state_e;

	npecs_state_e state;
	npecs_op_e    op;
	logic [11:0]  colAddr;
	logic [15:0]  rowAddr;
	logic [7:0]   dataReg;
	logic [7:0]   statusByte;
	logic         wpEnable;
	logic         refused;
	logic         readDone;
	logic         cacheActive;
	logic         cachePend;
	logic [9:0]   cacheBlk;
	logic [7:0]   cnt;
	logic [1:0]   addrIdx;
	logic         pollBit5;
	logic         go;
	logic         wrHit;
	logic         stepDone;
	logic [7:0]   cmd1;
	logic [7:0]   cmd2;
	logic         hasAddr;
	logic         hasCmd2;
	logic         waitsRb;
	logic [1:0]   addrFirst;
	logic [1:0]   addrLast;
	logic         needPoll5;
	logic         isCacheRd;
	logic         refuse;
	logic [7:0]   addrByte;
	npecs_op_e    reqOp;

	////////////////////////////////////////////////////////////////////////
	// Register bus slave.

	// Write address and data are taken together while no response waits.
	assign sAwready = sAwvalid && sWvalid && !sBvalid;
	assign sWready  = sAwready;
	assign wrHit    = sAwready;
	assign sArready = !sRvalid;
	assign reqOp    = npecs_op_e'(sWdata[3:0]);
	assign go       = wrHit && sAwaddr == REG_CTRL && sWstrb[0];

	// Write responses; a control write while busy, a status write or a write above the config offset errors.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sBvalid <= 1'b0;
			sBresp  <= RESP_OKAY;
		end else if (wrHit) begin
			sBvalid <= 1'b1;
			if (sAwaddr == REG_CTRL && state != S_IDLE)
				sBresp <= RESP_SLVERR;
			else if (sAwaddr == REG_STATUS || sAwaddr > REG_CONFIG)
				sBresp <= RESP_SLVERR;
			else
				sBresp <= RESP_OKAY;
		end else if (sBready) begin
			sBvalid <= 1'b0;
		end
	end

	// Plain software registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			colAddr  <= 12'h000;
			rowAddr  <= 16'h0000;
			wpEnable <= 1'b0;
		end else if (wrHit) begin
			if (sAwaddr == REG_COL)
				colAddr <= sWdata[11:0];
			if (sAwaddr == REG_ROW)
				rowAddr <= sWdata[15:0];
			if (sAwaddr == REG_CONFIG)
				wpEnable <= sWdata[0];
		end
	end

	// Read data; the status word shows sequencer flags, the die's last status byte and the ready/busy pin.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sRvalid <= 1'b0;
			sRdata  <= 32'h0000_0000;
			sRresp  <= RESP_OKAY;
		end else if (sArvalid && sArready) begin
			sRvalid <= 1'b1;
			sRresp  <= RESP_OKAY;
			case (sAraddr)
				REG_CTRL:   sRdata <= {28'h0000000, op};
				REG_COL:    sRdata <= {20'h00000, colAddr};
				REG_ROW:    sRdata <= {16'h0000, rowAddr};
				REG_DATA:   sRdata <= {24'h000000, dataReg};
				REG_STATUS: sRdata <= {14'h0000, cachePend, readyBusyOutN,
					statusByte, 4'h0, cacheActive, readDone, refused,
					state != S_IDLE};
				REG_CONFIG: sRdata <= {31'h00000000, wpEnable};
				default: begin
					sRdata <= 32'h0000_0000;
					sRresp <= RESP_SLVERR;
				end
			endcase
		end else if (sRready) begin
			sRvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operation decode.

	// Command codes and address cycles of each operation.
	always_comb begin
		cmd1      = CMD_READ;
		cmd2      = CMD_READ_GO;
		hasAddr   = 1'b1;
		hasCmd2   = 1'b0;
		waitsRb   = 1'b0;
		addrFirst = 2'd0;
		addrLast  = 2'd3;
		case (op)
			OP_READ: begin
				hasCmd2 = 1'b1;
				waitsRb = 1'b1;
			end
			OP_READ_CB: begin
				cmd2    = CMD_READ_CB;
				hasCmd2 = 1'b1;
				waitsRb = 1'b1;
			end
			OP_CACHE_SEQ: begin
				cmd1    = CMD_CACHE_RD;
				hasAddr = 1'b0;
				waitsRb = 1'b1;
			end
			OP_CACHE_END: begin
				cmd1    = CMD_CACHE_END;
				hasAddr = 1'b0;
				waitsRb = 1'b1;
			end
			OP_PROG_SETUP: cmd1 = CMD_LOAD;
			OP_CB_PROG:    cmd1 = CMD_RANDIN;
			OP_RAND_IN: begin
				cmd1     = CMD_RANDIN;
				addrLast = 2'd1;
			end
			OP_PROG_CONF: begin
				cmd1    = CMD_PROG;
				hasAddr = 1'b0;
				waitsRb = 1'b1;
			end
			OP_CACHE_CONF: begin
				cmd1    = CMD_CACHE_PG;
				hasAddr = 1'b0;
				waitsRb = 1'b1;
			end
			OP_ERASE: begin
				cmd1      = CMD_ERASE;
				cmd2      = CMD_ERASE_GO;
				hasCmd2   = 1'b1;
				waitsRb   = 1'b1;
				addrFirst = 2'd2;
			end
			default: hasAddr = 1'b0;
		endcase
	end

	// Row cycles carry page bits low and block bits high.
	always_comb begin
		case (addrIdx)
			2'd0:    addrByte = colAddr[7:0];
			2'd1:    addrByte = {4'h0, colAddr[11:8]};
			2'd2:    addrByte = rowAddr[7:0];
			default: addrByte = rowAddr[15:8];
		endcase
	end

	// Checks made when software starts an operation.
	assign isCacheRd = reqOp == OP_CACHE_SEQ || reqOp == OP_CACHE_END;
	assign needPoll5 = cachePend && (reqOp == OP_READ ||
		reqOp == OP_READ_CB || reqOp == OP_ERASE || isCacheRd);
	assign refuse = (isCacheRd && !readDone) ||
		(reqOp == OP_CACHE_SEQ && rowAddr == LAST_ROW) ||
		(reqOp == OP_PROG_SETUP && cacheActive &&
		rowAddr[15:PAGE_BITS] != cacheBlk);
	assign stepDone = cnt == STROBE_LAST;

	////////////////////////////////////////////////////////////////////////
	// Sequencer.

	// Walks command, address, data, busy wait and status steps.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state    <= S_IDLE;
			op       <= OP_STATUS;
			cnt      <= 8'h00;
			addrIdx  <= 2'd0;
			pollBit5 <= 1'b0;
			refused  <= 1'b0;
		end else begin
			// The busy wait runs past one strobe step, so it keeps counting.
			cnt <= (state == S_IDLE || (stepDone && state != S_WB)) ?
				8'h00 : cnt + 8'h01;
			case (state)
				S_IDLE: if (go) begin
					op       <= reqOp;
					refused  <= refuse;
					pollBit5 <= needPoll5;
					addrIdx  <= (reqOp == OP_ERASE) ? 2'd2 : 2'd0;
					if (refuse)
						state <= S_IDLE;
					else if (needPoll5 || isCacheRd)
						state <= S_POLL_CMD;
					else if (reqOp == OP_DIN)
						state <= S_DIN;
					else if (reqOp == OP_DOUT)
						state <= S_DOUT;
					else if (reqOp == OP_STATUS)
						state <= S_ST_CMD;
					else
						state <= S_CMD1;
				end
				S_POLL_CMD: if (stepDone)
					state <= S_POLL_RD;
				S_POLL_RD: if (stepDone) begin
					// The byte taken mid-strobe decides; the bus is released now.
					if (pollBit5 ? statusByte[SR_IDLE] :
						statusByte[SR_CACHE_RDY]) begin
						if (pollBit5 && (op == OP_CACHE_SEQ ||
							op == OP_CACHE_END)) begin
							pollBit5 <= 1'b0;
						end else begin
							pollBit5 <= 1'b0;
							state    <= S_CMD1;
						end
					end
				end
				S_CMD1: if (stepDone) begin
					if (hasAddr) begin
						state   <= S_ADDR;
						addrIdx <= addrFirst;
					end else
						state <= waitsRb ? S_WB : S_IDLE;
				end
				S_ADDR: if (stepDone) begin
					addrIdx <= addrIdx + 2'd1;
					if (addrIdx == addrLast)
						state <= hasCmd2 ? S_CMD2 : S_IDLE;
				end
				S_CMD2: if (stepDone)
					state <= waitsRb ? S_WB : S_IDLE;
				S_WB: if (cnt == WB_LAST)
					state <= S_WAITRB;
				S_WAITRB: begin
					cnt <= 8'h00;
					if (readyBusyOutN)
						state <= (op == OP_PROG_CONF || op == OP_ERASE ||
							op == OP_CACHE_CONF) ? S_ST_CMD : S_IDLE;
				end
				S_ST_CMD: if (stepDone)
					state <= S_ST_RD;
				default: if (stepDone)
					state <= S_IDLE;
			endcase
		end
	end

	// Sequence flags that guard cache read and cache program ordering.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			readDone    <= 1'b0;
			cacheActive <= 1'b0;
			cachePend   <= 1'b0;
			cacheBlk    <= 10'h000;
		end else if (state == S_POLL_RD && stepDone && pollBit5 &&
			statusByte[SR_IDLE]) begin
			cachePend <= 1'b0;
		end else if (state == S_CMD1 && stepDone) begin
			case (op)
				OP_READ, OP_READ_CB: readDone <= 1'b1;
				OP_PROG_SETUP: begin
					readDone <= 1'b0;
					if (!cacheActive)
						cacheBlk <= rowAddr[15:PAGE_BITS];
				end
				OP_ERASE, OP_CB_PROG: readDone <= 1'b0;
				OP_CACHE_CONF: begin
					cacheActive <= 1'b1;
					cachePend   <= 1'b1;
				end
				OP_PROG_CONF: begin
					cacheActive <= 1'b0;
					cachePend   <= 1'b0;
				end
				default: readDone <= readDone;
			endcase
		end
	end

	// Bytes read back from the die: status or page data.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			statusByte <= 8'h00;
			dataReg    <= 8'h00;
		end else begin
			// A software write to the data register never drops a status byte.
			if (cnt == STROBE_HALF && (state == S_ST_RD || state == S_POLL_RD))
				statusByte <= dqIn;
			if (wrHit && sAwaddr == REG_DATA && sWstrb[0])
				dataReg <= sWdata[7:0];
			else if (cnt == STROBE_HALF && state == S_DOUT)
				dataReg <= dqIn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, registered one cycle behind the sequencer.

	// Strobes go low for the first half of each step and high for the rest.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			nandPins <= '{cle: 1'b0, ale: 1'b0, ceN: 1'b1, weN: 1'b1,
				reN: 1'b1, wpN: 1'b0};
			dqOut    <= 8'h00;
			dqOe     <= 1'b0;
		end else begin
			nandPins.wpN <= wpEnable;
			nandPins.ceN <= state == S_IDLE;
			nandPins.cle <= state == S_CMD1 || state == S_CMD2 ||
				state == S_ST_CMD || state == S_POLL_CMD;
			nandPins.ale <= state == S_ADDR;
			nandPins.weN <= !((state == S_CMD1 || state == S_CMD2 ||
				state == S_ADDR || state == S_DIN || state == S_ST_CMD ||
				state == S_POLL_CMD) && cnt < STROBE_HALF);
			nandPins.reN <= !((state == S_ST_RD || state == S_POLL_RD ||
				state == S_DOUT) && cnt < STROBE_HALF);
			dqOe <= state == S_CMD1 || state == S_CMD2 || state == S_ADDR ||
				state == S_DIN || state == S_ST_CMD || state == S_POLL_CMD;
			case (state)
				S_CMD1:   dqOut <= cmd1;
				S_CMD2:   dqOut <= cmd2;
				S_ADDR:   dqOut <= addrByte;
				S_DIN:    dqOut <= dataReg;
				default:  dqOut <= CMD_STATUS;
			endcase
		end
	end

endmodule

// *** npecs_pkg.sv ***
// Constants, types and register map of the NAND sequencing host controller.
package npecs_pkg;

	// Clock rate and pin timing, turned into clock cycles.
	localparam int CLK_MHZ        = 250;
	localparam int T_STROBE_NS    = 30; // Least low and high time of a strobe.
	localparam int T_WB_NS        = 100; // Longest delay before busy shows.
	localparam int STROBE_CYC     = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int WB_CYC         = (T_WB_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] STROBE_LAST = 8'(2 * STROBE_CYC - 1);
	localparam logic [7:0] STROBE_HALF = 8'(STROBE_CYC);
	localparam logic [7:0] WB_LAST     = 8'(WB_CYC - 1);

	// Software register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_COL    = 8'h04;
	localparam logic [7:0] REG_ROW    = 8'h08;
	localparam logic [7:0] REG_DATA   = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CONFIG = 8'h14;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Row layout: page in the low bits, block above.
	localparam int PAGE_BITS = 6;
	localparam logic [15:0] LAST_ROW = 16'hFFFF;

	// Device command codes.
	localparam logic [7:0] CMD_READ     = 8'h00;
	localparam logic [7:0] CMD_READ_GO  = 8'h30;
	localparam logic [7:0] CMD_READ_CB  = 8'h35;
	localparam logic [7:0] CMD_CACHE_RD = 8'h31;
	localparam logic [7:0] CMD_CACHE_END = 8'h3F;
	localparam logic [7:0] CMD_LOAD     = 8'h80;
	localparam logic [7:0] CMD_RANDIN   = 8'h85;
	localparam logic [7:0] CMD_PROG     = 8'h10;
	localparam logic [7:0] CMD_CACHE_PG = 8'h15;
	localparam logic [7:0] CMD_ERASE    = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_STATUS   = 8'h70;

	// Status byte bit positions.
	localparam int SR_FAIL      = 0;
	localparam int SR_PREV_FAIL = 1;
	localparam int SR_IDLE      = 5;
	localparam int SR_CACHE_RDY = 6;

	// Operations that software starts through the control register.
	typedef enum logic [3:0] {
		OP_READ, OP_READ_CB, OP_CACHE_SEQ, OP_CACHE_END, OP_PROG_SETUP,
		OP_RAND_IN, OP_DIN, OP_DOUT, OP_PROG_CONF, OP_CACHE_CONF,
		OP_ERASE, OP_STATUS, OP_CB_PROG
	} npecs_op_e;

	// Control pins towards the flash die.
	typedef struct packed {
		logic cle;
		logic ale;
		logic ceN;
		logic weN;
		logic reN;
		logic wpN;
	} npecs_pins_s;

endpackage

// *** npecs_host_sva.sv ***
// Port checks of the NAND sequencing host controller, bound to its top.
`timescale 1ns/100ps
module npecs_host_sva
	import npecs_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   rst_n,
	input wire logic                   sAwvalid,
	input wire logic                   sWvalid,
	input wire logic                   sAwready,
	input wire logic                   sBvalid,
	input wire logic                   sBready,
	input wire logic [1:0]             sBresp,
	input wire logic                   sArvalid,
	input wire logic                   sArready,
	input wire logic                   sRvalid,
	input wire logic                   sRready,
	input wire logic [31:0]            sRdata,
	input wire npecs_pkg::npecs_pins_s nandPins,
	input wire logic [7:0]             dqOut,
	input wire logic                   dqOe,
	input wire logic                   readyBusyOutN
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Register bus handshakes.
	property p_awReady;
		sAwready == (sAwvalid && sWvalid && !sBvalid);
	endproperty
	a_awReady: assert property (p_awReady) else $error("write ready wrong");
	property p_bAnswer;
		sAwvalid && sAwready |=> sBvalid;
	endproperty
	a_bAnswer: assert property (p_bAnswer) else $error("no write answer");
	property p_bHold;
		sBvalid && !sBready |=> sBvalid && $stable(sBresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("write answer dropped");
	property p_rAnswer;
		sArvalid && sArready |=> sRvalid;
	endproperty
	a_rAnswer: assert property (p_rAnswer) else $error("no read answer");
	property p_rHold;
		sRvalid && !sRready |=> sRvalid && $stable(sRdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read answer dropped");

	////////////////////////////////////////////////////////////////////////
	// Flash pin sequencing.
	property p_weShape;
		$fell(nandPins.weN) |-> (!nandPins.weN) [*8] ##1 nandPins.weN;
	endproperty
	a_weShape: assert property (p_weShape) else $error("write strobe width");
	property p_reShape;
		$fell(nandPins.reN) |-> (!nandPins.reN) [*8] ##1 nandPins.reN;
	endproperty
	a_reShape: assert property (p_reShape) else $error("read strobe width");
	property p_ceSel;
		!nandPins.weN || !nandPins.reN |-> !nandPins.ceN && !(nandPins.cle && nandPins.ale);
	endproperty
	a_ceSel: assert property (p_ceSel) else $error("strobe without select");
	property p_busyCmd;
		$fell(nandPins.weN) && !readyBusyOutN |-> nandPins.cle && dqOut == CMD_STATUS;
	endproperty
	a_busyCmd: assert property (p_busyCmd) else $error("cycle while busy");
	property p_noDrive;
		!nandPins.reN |-> !dqOe;
	endproperty
	a_noDrive: assert property (p_noDrive) else $error("drive during read");

	// Main flows seen on the pins, and a bus error answer.
	cover property ($fell(nandPins.weN) && nandPins.cle && dqOut == CMD_PROG);
	cover property ($fell(nandPins.weN) && nandPins.cle && dqOut == CMD_CACHE_PG);
	cover property ($fell(nandPins.weN) && nandPins.cle && dqOut == CMD_ERASE_GO);
	cover property (sBvalid && sBresp == RESP_SLVERR);
endmodule

bind npecs_host npecs_host_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
	.sAwvalid(sAwvalid), .sWvalid(sWvalid), .sAwready(sAwready),
	.sBvalid(sBvalid), .sBready(sBready), .sBresp(sBresp),
	.sArvalid(sArvalid), .sArready(sArready), .sRvalid(sRvalid),
	.sRready(sRready), .sRdata(sRdata), .nandPins(nandPins),
	.dqOut(dqOut), .dqOe(dqOe), .readyBusyOutN(readyBusyOutN));

// *** npecs_nand_model.sv ***
// Behavioural model of the flash die that the host controller drives.
`timescale 1ns/100ps
module npecs_nand_model
	import npecs_pkg::*;
(
	input  wire npecs_pkg::npecs_pins_s pins,
	input  wire logic [7:0]             dqHost,
	output logic [7:0]                  dqDev,
	output logic                        rbN
);
	localparam int BUSY_NS = 400;
	logic [7:0]  page [0:4095];
	logic [11:0] col;
	logic [7:0]  rdByte;
	logic        statusMode;
	logic        busy;
	int          addrCnt;
	event        goBusy;

	// Erased page buffer, idle device in read mode.
	initial begin
		busy = 1'b0;
		statusMode = 1'b0;
		col = 12'h000;
		addrCnt = 0;
		rdByte = 8'hFF;
		foreach (page[i]) page[i] = 8'hFF;
	end

	// One internal operation holds the device busy for a fixed span.
	always @(goBusy) begin
		busy = 1'b1;
		#(BUSY_NS) busy = 1'b0;
	end
	assign rbN = !busy;
	// A released bus shows the inverse of the last byte, not a held value.
	assign dqDev = (!pins.reN && !pins.ceN) ? rdByte : ~rdByte;

	////////////////////////////////////////////////////////////////////////
	// Command, address and data cycles latched on the write strobe rise.
	always @(posedge pins.weN) begin
		if (pins.ceN) begin
		end else if (pins.cle) begin
			if (!busy || dqHost == CMD_STATUS) begin
				statusMode = (dqHost == CMD_STATUS);
				addrCnt = 0;
				if (dqHost == CMD_CACHE_RD || dqHost == CMD_CACHE_END)
					col = 12'h000;
				if (dqHost inside {CMD_READ_GO, CMD_READ_CB, CMD_CACHE_RD,
					CMD_CACHE_END})
					-> goBusy;
				if (pins.wpN && dqHost inside {CMD_PROG, CMD_CACHE_PG,
					CMD_ERASE_GO})
					-> goBusy;
			end
		end else if (pins.ale) begin
			if (addrCnt == 0)
				col[7:0] = dqHost;
			if (addrCnt == 1)
				col[11:8] = dqHost[3:0];
			addrCnt = addrCnt + 1;
		end else begin
			page[col] = dqHost;
			col = col + 12'h001;
		end
	end

	// Status byte in status mode, else page data; bits 1 and 0 report pass.
	always @(negedge pins.reN) begin
		if (!pins.ceN && statusMode)
			rdByte = {pins.wpN, !busy, !busy, 5'h00};
		else if (!pins.ceN) begin
			rdByte = page[col];
			col = col + 12'h001;
		end
	end
endmodule

// *** npecs_host_test.sv ***
// Register-level testbench of the NAND sequencing host controller.
`timescale 1ns/100ps
module npecs_host_test;
	import npecs_pkg::*;
	logic               clk_sys, rst_n;
	logic [7:0]         sAwaddr, sAraddr, dqIn, dqOut;
	logic [31:0]        sWdata, sRdata, d;
	logic [3:0]         sWstrb;
	logic               sAwvalid, sAwready, sWvalid, sWready, sBvalid;
	logic               sBready, sArvalid, sArready, sRvalid, sRready;
	logic [1:0]         sBresp, sRresp, r;
	logic               dqOe, readyBusyOutN;
	npecs_pins_s        nandPins;
	int                 failures, comparisons;

	npecs_host u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sAwaddr(sAwaddr),
		.sAwvalid(sAwvalid), .sAwready(sAwready), .sWdata(sWdata),
		.sWstrb(sWstrb), .sWvalid(sWvalid), .sWready(sWready),
		.sBresp(sBresp), .sBvalid(sBvalid), .sBready(sBready),
		.sAraddr(sAraddr), .sArvalid(sArvalid), .sArready(sArready),
		.sRdata(sRdata), .sRresp(sRresp), .sRvalid(sRvalid),
		.sRready(sRready), .nandPins(nandPins), .dqIn(dqIn),
		.dqOut(dqOut), .dqOe(dqOe), .readyBusyOutN(readyBusyOutN));
	npecs_nand_model u_nand (.pins(nandPins), .dqHost(dqOut), .dqDev(dqIn),
		.rbN(readyBusyOutN));

	// Clock at 250 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////
	// Comparison, bus tasks and the closing verdict.
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		sAwaddr <= a;
		sWdata <= v;
		sAwvalid <= 1'b1;
		sWvalid <= 1'b1;
		sBready <= 1'b1;
		do @(posedge clk_sys); while (sAwready !== 1'b1);
		sAwvalid <= 1'b0;
		sWvalid <= 1'b0;
		do @(posedge clk_sys); while (sBvalid !== 1'b1);
		r = sBresp;
		sBready <= 1'b0;
	endtask
	task automatic axiRead(input logic [7:0] a);
		@(posedge clk_sys);
		sAraddr <= a;
		sArvalid <= 1'b1;
		sRready <= 1'b1;
		do @(posedge clk_sys); while (sArready !== 1'b1);
		sArvalid <= 1'b0;
		do @(posedge clk_sys); while (sRvalid !== 1'b1);
		d = sRdata;
		r = sRresp;
		sRready <= 1'b0;
	endtask
	// Start one operation and poll the busy flag until it finishes.
	task automatic runOp(input npecs_op_e op);
		axiWrite(REG_CTRL, 32'(op));
		do axiRead(REG_STATUS); while (d[0] !== 1'b0);
	endtask
	task automatic expectStatus(input logic [31:0] mask, input logic [31:0] e);
		axiRead(REG_STATUS);
		check("status", d & mask, e);
	endtask
	task print_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#200000;
		failures++;
		print_verdict;
	end

	////////////////////////////////////////////////////////////////////////
	// Test sequence.
	initial begin
		{sAwaddr, sAraddr, sWdata, sAwvalid, sWvalid, sBready} = '0;
		{sArvalid, sRready, failures, comparisons} = '0;
		sWstrb = 4'hF;
		rst_n = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check("pins", 32'(nandPins), 32'h0000000E);
		axiRead(REG_CONFIG);
		check("config", d, 32'h0);
		runOp(OP_CACHE_SEQ);
		expectStatus(32'h2, 32'h2);
		axiWrite(REG_CONFIG, 32'h1);
		repeat (3) @(posedge clk_sys);
		check("wp", 32'(nandPins.wpN), 32'h1);
		// Program with a redirected column, refused write while busy.
		axiWrite(REG_COL, 32'h3);
		axiWrite(REG_ROW, 32'h41);
		runOp(OP_PROG_SETUP);
		axiWrite(REG_COL, 32'h7);
		runOp(OP_RAND_IN);
		axiWrite(REG_DATA, 32'hA5);
		runOp(OP_DIN);
		axiWrite(REG_CTRL, 32'(OP_PROG_CONF));
		axiWrite(REG_CTRL, 32'(OP_STATUS));
		check("busy ctrl", 32'(r), 32'(RESP_SLVERR));
		do axiRead(REG_STATUS); while (d[0] !== 1'b0);
		runOp(OP_STATUS);
		expectStatus(32'h1FF03, 32'h1E000);
		axiWrite(REG_STATUS, 32'h0);
		check("ro status", 32'(r), 32'(RESP_SLVERR));
		axiRead(8'h18);
		check("unmapped", d | 32'(r), 32'(RESP_SLVERR));
		// Read back the redirected byte.
		runOp(OP_READ);
		runOp(OP_DOUT);
		axiRead(REG_DATA);
		check("dout", d & 32'hFF, 32'hA5);
		// Cache read: last page refused, then a sequence and its end.
		axiWrite(REG_ROW, 32'hFFFF);
		runOp(OP_CACHE_SEQ);
		expectStatus(32'h2, 32'h2);
		axiWrite(REG_ROW, 32'h42);
		runOp(OP_CACHE_SEQ);
		expectStatus(32'h4002, 32'h4000);
		runOp(OP_CACHE_END);
		expectStatus(32'h4002, 32'h4000);
		// Two cache-programmed pages in one block, ended by 10h.
		axiWrite(REG_ROW, 32'h80);
		runOp(OP_PROG_SETUP);
		runOp(OP_DIN);
		runOp(OP_CACHE_CONF);
		axiWrite(REG_ROW, 32'h81);
		runOp(OP_PROG_SETUP);
		expectStatus(32'h2, 32'h0);
		runOp(OP_PROG_CONF);
		expectStatus(32'h6303, 32'h6000);
		// Copy-back to another page, ended by 10h.
		axiWrite(REG_ROW, 32'h41);
		runOp(OP_READ_CB);
		axiWrite(REG_ROW, 32'h45);
		runOp(OP_CB_PROG);
		runOp(OP_PROG_CONF);
		expectStatus(32'h1FF03, 32'h1E000);
		// A cache program left open by 15h makes the erase poll bit 5 first.
		axiWrite(REG_ROW, 32'h80);
		runOp(OP_PROG_SETUP);
		runOp(OP_CACHE_CONF);
		expectStatus(32'h20000, 32'h20000);
		runOp(OP_ERASE);
		expectStatus(32'h1FF03, 32'h1E000);
		expectStatus(32'h20000, 32'h0);
		print_verdict;
	end
endmodule
